// File: hdl/lsi_pkg.sv
// Shared constants and types of the light sensor serial interface.
package lsi_pkg;

  // ****************************************************************
  // Bus timing
  // ****************************************************************
  localparam int CLK_HZ = 40000000;
  localparam int SCL_HZ = 100000;
  localparam int QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);
  localparam int OSC_HZ = 342000;
  localparam int OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;

  // ****************************************************************
  // Addressing and register map
  // ****************************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h44;
  localparam logic [2:0] REG_CONFIG = 3'h0;
  localparam logic [2:0] REG_CONTROL = 3'h1;
  localparam logic [2:0] REG_UPPER = 3'h2;
  localparam logic [2:0] REG_LOWER = 3'h3;
  localparam logic [2:0] REG_RESULT_LO = 3'h4;
  localparam logic [2:0] REG_RESULT_HI = 3'h5;
  localparam logic [2:0] REG_COUNT_LO = 3'h6;
  localparam logic [2:0] REG_COUNT_HI = 3'h7;

  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [1:0] GAIN_RST = 2'h0;
  localparam logic [1:0] PERSIST_RST = 2'h0;
  localparam logic [7:0] UPPER_RST = 8'hff;
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFG_RUN_BIT = 7;
  localparam int CFG_PD_BIT = 6;
  localparam int CFG_TIM_BIT = 5;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CTL_FLAG_BIT = 5;
  localparam int CTL_GAIN_LSB = 2;
  localparam int CTL_PERSIST_LSB = 0;
  localparam int CMD_RESTART_BIT = 7;
  localparam int CMD_CLEAR_BIT = 6;
  localparam logic [1:0] MODE_LIGHT = 2'h2;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_ACK = 3'b010,
    S_TX = 3'b011,
    S_TXACK = 3'b100
  } lsi_slave_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } lsi_host_state_t;

endpackage

// File: hdl/lsi_bus_if.sv
// Two-wire bus and alert line joining the sensor and its bus master.
`timescale 1ns/100ps
interface lsi_bus_if;
  logic scl;
  logic sda_m_oe;
  logic sda_s_oe;
  logic int_oe;
  logic sda;
  logic int_n;

  // Open-drain lines resolve as wired-AND with a pull-up.
  assign sda = !(sda_m_oe | sda_s_oe);
  assign int_n = !int_oe;

  modport device(
    input scl,
    input sda,
    output sda_s_oe,
    output int_oe
  );

  modport host(
    output scl,
    output sda_m_oe,
    input sda,
    input int_n
  );
endinterface

// File: hdl/lsi_device.sv
// Sensor end: serial slave, register file, integration timing, alert.
//
// Summary of operation
// [RULE1] Answer only slave address 1000100.
// [RULE2] Eight byte registers on the bus.
// [RULE3] Configuration and control keep values until rewritten.
// [RULE4] Addresses 4 to 7 are read-only.
// [RULE5] Result and timer show latest integration.
// [RULE6] Upper limit resets to ff, others 00.
// [RULE7] Address bit 7 restarts integration.
// [RULE8] Address bit 6 clears the alert.
// [RULE9] Alert pin active low, pull down only.
// [RULE10] Alert when outside upper or lower limit.
// [RULE11] Alert needs consecutive out-of-window results.
// [RULE12] Internal timing uses oscillator and n-bit counter.
// [RULE13] Host timing spans two restart commands.
// [RULE14] Result is signed 15 bits, two bytes.
// [RULE15] Four selectable full-scale ranges.
// [RULE16] Receiver pulls data low during acknowledge.
// [RULE17] Master opens with start and address byte.
// [RULE18] Master closes with stop condition.
// [RULE19] Persistence codes give 1, 4, 8, 16.
// [RULE20] Limits are upper byte, low byte zero.
// [RULE21] Width codes give 65536, 4096, 256, 16.
// [RULE22] Alert flag set on trigger, cleared by zero.
// [RULE23] Write sets pointer; reads use that pointer.
// [RULE24] Result bytes captured together at integration end.
`timescale 1ns/100ps
module lsi_device #(
  parameter int OSC_DIV = lsi_pkg::OSC_DIV_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  lsi_bus_if.device BUS,
  input wire logic [14:0] LIGHT_SAMPLE,
  output logic [1:0] LUX_RANGE,
  output logic INTEG_ACTIVE,
  output logic INTEG_DONE
);

  generate
    if (OSC_DIV < 4 || OSC_DIV > 65535)
    begin : g_bad_div
      $error("OSC_DIV must lie between 4 and 65535");
    end
  endgenerate

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [15:0] width_last(input logic [1:0] w);
    case (w)
      2'h0: width_last = 16'hffff;
      2'h1: width_last = 16'h0fff;
      2'h2: width_last = 16'h00ff;
      default: width_last = 16'h000f;
    endcase
  endfunction

  function automatic logic [4:0] persist_need(input logic [1:0] p);
    case (p)
      2'h0: persist_need = 5'h01;
      2'h1: persist_need = 5'h04;
      2'h2: persist_need = 5'h08;
      default: persist_need = 5'h10;
    endcase
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic scl_q, scl_p, sda_q, sda_p;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  lsi_pkg::lsi_slave_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic rw;
  logic [2:0] ptr;
  logic sda_drive;
  logic wr_en;
  logic [2:0] wr_ptr;
  logic [7:0] wr_data;
  logic restart_cmd, clear_cmd;
  logic [7:0] config_reg;
  logic [1:0] gain, persist;
  logic alert_flag;
  logic [7:0] upper, lower;
  logic [15:0] result, count;
  logic [7:0] rd_byte;
  logic conv_on, tick, integ_end, out_win, alert_set;
  logic [15:0] div_cnt, tick_cnt;
  logic [4:0] persist_cnt;
  logic signed [16:0] sample17, upper17, lower17;

  // ****************************************************************
  // Bus edge detection
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      scl_q <= 1'b1;
      scl_p <= 1'b1;
      sda_q <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_q <= BUS.scl;
      scl_p <= scl_q;
      sda_q <= BUS.sda;
      sda_p <= sda_q;
    end
  end

  assign scl_rise = scl_q & !scl_p;
  assign scl_fall = !scl_q & scl_p;
  assign bus_start = scl_q & scl_p & sda_p & !sda_q; // [RULE17]
  assign bus_stop = scl_q & scl_p & !sda_p & sda_q; // [RULE18]

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb
  begin
    case (ptr) // [RULE2]
      lsi_pkg::REG_CONFIG: rd_byte = config_reg;
      lsi_pkg::REG_CONTROL: rd_byte = {2'h0, alert_flag, 1'b0, gain, persist};
      lsi_pkg::REG_UPPER: rd_byte = upper;
      lsi_pkg::REG_LOWER: rd_byte = lower;
      lsi_pkg::REG_RESULT_LO: rd_byte = result[7:0];
      lsi_pkg::REG_RESULT_HI: rd_byte = result[15:8];
      lsi_pkg::REG_COUNT_LO: rd_byte = count[7:0];
      default: rd_byte = count[15:8];
    endcase
  end

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  // Data changes a few clocks after the falling clock edge, which keeps
  // hold time on the line while the master samples a quarter period after the rising edge.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= lsi_pkg::S_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      byte_cnt <= 2'h0;
      rw <= 1'b0;
      ptr <= 3'h0;
      sda_drive <= 1'b0;
      wr_en <= 1'b0;
      wr_ptr <= 3'h0;
      wr_data <= 8'h00;
      restart_cmd <= 1'b0;
      clear_cmd <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      restart_cmd <= 1'b0;
      clear_cmd <= 1'b0;
      if (bus_start)
      begin
        state <= lsi_pkg::S_RX;
        bit_cnt <= 4'h0;
        byte_cnt <= 2'h0;
        sda_drive <= 1'b0;
      end
      else if (bus_stop)
      begin
        state <= lsi_pkg::S_IDLE;
        sda_drive <= 1'b0;
      end
      else
      begin
        case (state)
          lsi_pkg::S_RX:
            if (scl_rise)
            begin
              shift <= {shift[6:0], sda_q};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              byte_cnt <= (byte_cnt == 2'h2) ? 2'h2 : byte_cnt + 2'h1;
              state <= lsi_pkg::S_ACK;
              sda_drive <= 1'b1; // [RULE16]
              if (byte_cnt == 2'h0)
              begin
                rw <= shift[0];
                if (shift[7:1] != lsi_pkg::SLAVE_ADDR) // [RULE1]
                begin
                  state <= lsi_pkg::S_IDLE;
                  sda_drive <= 1'b0;
                end
              end
              else if (byte_cnt == 2'h1)
              begin
                ptr <= shift[2:0]; // [RULE23]
                restart_cmd <= shift[lsi_pkg::CMD_RESTART_BIT]; // [RULE7]
                clear_cmd <= shift[lsi_pkg::CMD_CLEAR_BIT]; // [RULE8]
              end
              else
              begin
                wr_en <= 1'b1;
                wr_ptr <= ptr;
                wr_data <= shift;
                ptr <= ptr + 3'h1;
              end
            end
          lsi_pkg::S_ACK:
            if (scl_fall)
            begin
              if (rw)
              begin
                state <= lsi_pkg::S_TX;
                sda_drive <= !rd_byte[7];
                shift <= {rd_byte[6:0], 1'b0};
                bit_cnt <= 4'h1;
                ptr <= ptr + 3'h1;
              end
              else
              begin
                state <= lsi_pkg::S_RX;
                sda_drive <= 1'b0;
              end
            end
          lsi_pkg::S_TX:
            if (scl_fall)
            begin
              if (bit_cnt == 4'h8)
              begin
                sda_drive <= 1'b0;
                state <= lsi_pkg::S_TXACK;
              end
              else
              begin
                sda_drive <= !shift[7];
                shift <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          lsi_pkg::S_TXACK:
            if (scl_rise)
              state <= sda_q ? lsi_pkg::S_IDLE : lsi_pkg::S_ACK; // [RULE16]
          default:
            sda_drive <= 1'b0;
        endcase
      end
    end
  end

  assign BUS.sda_s_oe = sda_drive;

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      config_reg <= lsi_pkg::CONFIG_RST; // [RULE6]
      gain <= lsi_pkg::GAIN_RST;
      persist <= lsi_pkg::PERSIST_RST;
      upper <= lsi_pkg::UPPER_RST; // [RULE6]
      lower <= lsi_pkg::LOWER_RST;
    end
    else if (wr_en)
    begin
      // Only host writes reach these; nothing else alters them.
      case (wr_ptr) // [RULE3]
        lsi_pkg::REG_CONFIG: config_reg <= wr_data;
        lsi_pkg::REG_CONTROL:
        begin
          gain <= wr_data[lsi_pkg::CTL_GAIN_LSB +: 2]; // [RULE15]
          persist <= wr_data[lsi_pkg::CTL_PERSIST_LSB +: 2];
        end
        lsi_pkg::REG_UPPER: upper <= wr_data;
        lsi_pkg::REG_LOWER: lower <= wr_data;
        default: upper <= upper; // [RULE4]
      endcase
    end
  end

  // ****************************************************************
  // Integration timing
  // ****************************************************************
  assign conv_on = config_reg[lsi_pkg::CFG_RUN_BIT]
                 & !config_reg[lsi_pkg::CFG_PD_BIT]
                 & (config_reg[lsi_pkg::CFG_MODE_LSB +: 2]
                    == lsi_pkg::MODE_LIGHT);
  assign tick = conv_on & (div_cnt == 16'h0000);
  assign integ_end = conv_on & (restart_cmd // [RULE13]
    | (!config_reg[lsi_pkg::CFG_TIM_BIT] & tick
       & (tick_cnt == width_last(config_reg[lsi_pkg::CFG_WIDTH_LSB +: 2]))));

  // The two upper ranges run the oscillator at double speed.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      div_cnt <= 16'h0000;
    else if (!conv_on || div_cnt == 16'h0000)
      div_cnt <= gain[1] ? 16'(OSC_DIV / 2 - 1) : 16'(OSC_DIV - 1); // [RULE15]
    else
      div_cnt <= div_cnt - 16'h0001;
  end

  // The timer saturates rather than wraps on a very long host interval.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      tick_cnt <= 16'h0000;
    else if (!conv_on || integ_end) // [RULE7]
      tick_cnt <= 16'h0000;
    else if (tick && tick_cnt != 16'hffff) // [RULE12] [RULE21]
      tick_cnt <= tick_cnt + 16'h0001;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      result <= lsi_pkg::DATA_RST;
      count <= lsi_pkg::DATA_RST;
    end
    else if (integ_end)
    begin
      result <= {LIGHT_SAMPLE[14], LIGHT_SAMPLE}; // [RULE5] [RULE14] [RULE24]
      count <= tick_cnt; // [RULE5]
    end
  end

  // ****************************************************************
  // Threshold window and alert
  // ****************************************************************
  assign sample17 = {{2{LIGHT_SAMPLE[14]}}, LIGHT_SAMPLE};
  assign upper17 = {1'b0, upper, 8'h00}; // [RULE20]
  assign lower17 = {1'b0, lower, 8'h00}; // [RULE20]
  assign out_win = (sample17 > upper17) || (sample17 < lower17); // [RULE10]
  assign alert_set = integ_end & out_win
                   & (persist_cnt + 5'h01 >= persist_need(persist)); // [RULE19]

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      persist_cnt <= 5'h00;
    else if (integ_end)
    begin
      if (!out_win)
        persist_cnt <= 5'h00; // [RULE11]
      else if (!alert_set)
        persist_cnt <= persist_cnt + 5'h01;
    end
  end

  // A new trigger in the cycle of a clear keeps the flag set.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      alert_flag <= 1'b0;
    else if (alert_set)
      alert_flag <= 1'b1; // [RULE22]
    else if (clear_cmd || (wr_en && wr_ptr == lsi_pkg::REG_CONTROL
             && !wr_data[lsi_pkg::CTL_FLAG_BIT]))
      alert_flag <= 1'b0; // [RULE8] [RULE22]
  end

  assign BUS.int_oe = alert_flag; // [RULE9]

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      LUX_RANGE <= lsi_pkg::GAIN_RST;
      INTEG_ACTIVE <= 1'b0;
      INTEG_DONE <= 1'b0;
    end
    else
    begin
      LUX_RANGE <= gain; // [RULE15]
      INTEG_ACTIVE <= conv_on;
      INTEG_DONE <= integ_end;
    end
  end

endmodule

// File: hdl/lsi_host.sv
// Bus master end: issues register writes, reads and command writes.
`timescale 1ns/100ps
module lsi_host #(
  parameter int QUARTER = lsi_pkg::QUARTER_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  lsi_bus_if.host BUS,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_READ,
  input wire logic [7:0] CMD_REG,
  input wire logic CMD_HAS_DATA,
  input wire logic [7:0] CMD_DATA,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_NACK,
  output logic ALERT
);

  generate
    if (QUARTER < 4 || QUARTER > 65535)
    begin : g_bad_quarter
      $error("QUARTER must lie between 4 and 65535");
    end
  endgenerate

  lsi_pkg::lsi_host_state_t state;
  logic [15:0] q_cnt;
  logic qtick;
  logic [1:0] quarter;
  logic [3:0] bit_idx;
  logic [1:0] byte_idx;
  logic rd_phase, nack, scl, sda_low;
  logic c_read, c_has;
  logic [7:0] c_reg, c_data, rx, cur_byte;
  logic [1:0] last_idx;
  logic is_tx;
  logic [2:0] bsel;

  assign qtick = (q_cnt == 16'h0000);
  assign CMD_READY = (state == lsi_pkg::H_IDLE);
  assign is_tx = !(rd_phase && byte_idx == 2'h1);
  assign last_idx = (!rd_phase && !c_read && c_has) ? 2'h2 : 2'h1;
  assign bsel = 3'h7 - bit_idx[2:0];

  // ****************************************************************
  // Byte sequence
  // ****************************************************************
  // A read is a pointer write, a stop, then a fresh addressed read.
  always_comb
  begin
    case (byte_idx)
      2'h0: cur_byte = {lsi_pkg::SLAVE_ADDR, rd_phase}; // [RULE17]
      2'h1: cur_byte = c_reg; // [RULE23] [RULE7] [RULE13]
      default: cur_byte = c_data;
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      q_cnt <= 16'h0000;
    else if (state == lsi_pkg::H_IDLE || qtick)
      q_cnt <= 16'(QUARTER - 1);
    else
      q_cnt <= q_cnt - 16'h0001;
  end

  // ****************************************************************
  // Bus sequencer
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= lsi_pkg::H_IDLE;
      quarter <= 2'h0;
      bit_idx <= 4'h0;
      byte_idx <= 2'h0;
      rd_phase <= 1'b0;
      nack <= 1'b0;
      scl <= 1'b1;
      sda_low <= 1'b0;
      c_read <= 1'b0;
      c_has <= 1'b0;
      c_reg <= 8'h00;
      c_data <= 8'h00;
      rx <= 8'h00;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_NACK <= 1'b0;
    end
    else
    begin
      RSP_VALID <= 1'b0;
      if (state == lsi_pkg::H_IDLE)
      begin
        if (CMD_VALID)
        begin
          c_read <= CMD_READ;
          c_has <= CMD_HAS_DATA;
          c_reg <= CMD_REG;
          c_data <= CMD_DATA;
          rd_phase <= 1'b0;
          nack <= 1'b0;
          quarter <= 2'h0;
          state <= lsi_pkg::H_START;
        end
      end
      else if (qtick)
      begin
        quarter <= quarter + 2'h1;
        case (state)
          lsi_pkg::H_START:
            case (quarter) // [RULE17]
              2'h0:
              begin
                scl <= 1'b1;
                sda_low <= 1'b0;
              end
              2'h1: sda_low <= 1'b1;
              default:
              begin
                scl <= 1'b0;
                quarter <= 2'h0;
                bit_idx <= 4'h0;
                byte_idx <= 2'h0;
                state <= lsi_pkg::H_BIT;
              end
            endcase
          lsi_pkg::H_BIT:
            case (quarter)
              2'h0: sda_low <= is_tx && bit_idx != 4'h8 && !cur_byte[bsel];
              2'h1: scl <= 1'b1; // [RULE16]
              2'h2:
                if (bit_idx == 4'h8 && is_tx && BUS.sda)
                  nack <= 1'b1; // [RULE16]
                else if (!is_tx && bit_idx != 4'h8)
                  rx <= {rx[6:0], BUS.sda};
              default:
              begin
                scl <= 1'b0;
                if (bit_idx != 4'h8)
                  bit_idx <= bit_idx + 4'h1;
                else
                begin
                  bit_idx <= 4'h0;
                  if (nack || byte_idx == last_idx)
                    state <= lsi_pkg::H_STOP;
                  else
                    byte_idx <= byte_idx + 2'h1;
                end
              end
            endcase
          lsi_pkg::H_STOP:
            case (quarter) // [RULE18]
              2'h0: sda_low <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: sda_low <= 1'b0;
              default:
                if (!rd_phase && c_read && !nack)
                begin
                  rd_phase <= 1'b1;
                  state <= lsi_pkg::H_START;
                end
                else
                begin
                  state <= lsi_pkg::H_IDLE;
                  RSP_VALID <= 1'b1;
                  RSP_DATA <= rx;
                  RSP_NACK <= nack;
                end
            endcase
          default: state <= lsi_pkg::H_IDLE;
        endcase
      end
    end
  end

  assign BUS.scl = scl;
  assign BUS.sda_m_oe = sda_low;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ALERT <= 1'b0;
    else
      ALERT <= !BUS.int_n;
  end

endmodule

// File: testbench/lsi_bus_chk.sv
// Wire-level checks on the bus joining the sensor and its master.
`timescale 1ns/100ps
module lsi_bus_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic scl,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic int_oe,
  input wire logic sda,
  input wire logic int_n
);
  logic [7:0] idle_cnt;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // A bit's high phase, 16 cycles in the bench, is shorter than the 20 cycles asked for here.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      idle_cnt <= 8'h00;
    else if (!(scl && sda))
      idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff)
      idle_cnt <= idle_cnt + 8'h01;
  end

  property p_slave_edge;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  a_slave_edge: assert property (p_slave_edge)
    else $error("sensor moved data while clock high");

  property p_slave_hold;
    $rose(scl) |-> $stable(sda_s_oe) [*3];
  endproperty
  a_slave_hold: assert property (p_slave_hold)
    else $error("sensor data not held over clock high");

  property p_master_hold;
    $rose(scl) |-> $stable(sda_m_oe) [*3];
  endproperty
  a_master_hold: assert property (p_master_hold)
    else $error("master data not held over clock high");

  // While the clock is high only one end may hold the data line down.
  property p_one_puller;
    sda_s_oe && scl |-> !sda_m_oe;
  endproperty
  a_one_puller: assert property (p_one_puller)
    else $error("both ends pull data while clock high");

  property p_start;
    $fell(sda) && scl |-> (sda_m_oe && scl) [*3];
  endproperty
  a_start: assert property (p_start)
    else $error("bad start condition");

  property p_stop;
    $rose(sda) && scl |-> !sda_m_oe ##1 scl [*3];
  endproperty
  a_stop: assert property (p_stop)
    else $error("bad stop condition");

  property p_idle_free;
    idle_cnt > 8'h14 |-> !sda_s_oe;
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("sensor holds data line on idle bus");

  // The alert is only let go by a host write, so never on an idle bus.
  property p_alert_release;
    $fell(int_oe) |-> idle_cnt == 8'h00;
  endproperty
  a_alert_release: assert property (p_alert_release)
    else $error("alert released outside a bus write");
endmodule

// File: testbench/tb.sv
// Self-checking bench joining the sensor end and its bus master end.
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_reg = 8'h00;
  logic cmd_has_data = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic [14:0] light = 15'h0800;
  logic cmd_ready, rsp_valid, rsp_nack, alert, integ_active, integ_done;
  logic [7:0] rsp_data;
  logic [1:0] lux_range;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;

  lsi_bus_if bus();
  lsi_device #(.OSC_DIV(4)) i_lsi_device(.CLK(clk), .RST(rst), .BUS(bus),
    .LIGHT_SAMPLE(light), .LUX_RANGE(lux_range),
    .INTEG_ACTIVE(integ_active), .INTEG_DONE(integ_done));
  lsi_host #(.QUARTER(8)) i_lsi_host(.CLK(clk), .RST(rst), .BUS(bus),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_READ(cmd_read),
    .CMD_REG(cmd_reg), .CMD_HAS_DATA(cmd_has_data), .CMD_DATA(cmd_data),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_NACK(rsp_nack),
    .ALERT(alert));
  lsi_bus_chk i_lsi_bus_chk(.CLK(clk), .RST(rst), .scl(bus.scl),
    .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe),
    .int_oe(bus.int_oe), .sda(bus.sda), .int_n(bus.int_n));

  always #12.5 clk = ~clk;

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      print_verdict;
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // The wait is bounded so a silent master cannot hang the run.
  task xfer(input logic rd, input logic [7:0] r, input logic hd,
            input logic [7:0] d);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_reg <= r;
    cmd_has_data <= hd;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 4000);
    chk({15'h0000, rsp_valid}, 16'h0001);
    chk({15'h0000, rsp_nack}, 16'h0000);
  endtask

  task rd(input logic [7:0] r, input logic [7:0] e);
    xfer(1'b1, r, 1'b0, 8'h00);
    chk({8'h00, rsp_data}, {8'h00, e});
  endtask

  task wr(input logic [7:0] r, input logic [7:0] d);
    xfer(1'b0, r, 1'b1, d);
  endtask

  task wait_alert(input int n, input logic e);
    repeat (n) @(posedge clk);
    #1;
    chk({15'h0000, alert}, {15'h0000, e});
  endtask

  // The end-of-integration pulse stands one cycle, so it is polled each edge.
  task wait_done;
    int n;
    n = 0;
    while (integ_done !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({15'h0000, integ_done}, 16'h0001);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_defaults;
    for (int i = 0; i < 8; i++)
      rd(8'(i), (i == 2) ? 8'hff : 8'h00);
    $display("defaults done");
  endtask

  task t_regs;
    wr(8'h00, 8'h43);
    wr(8'h01, 8'h0e);
    wr(8'h02, 8'h5a);
    wr(8'h03, 8'h21);
    wr(8'h04, 8'h77);
    rd(8'h00, 8'h43);
    rd(8'h01, 8'h0e);
    rd(8'h02, 8'h5a);
    rd(8'h03, 8'h21);
    rd(8'h04, 8'h00);
    chk({14'h0000, lux_range}, 16'h0003);
    chk({15'h0000, integ_active}, 16'h0000);
    $display("registers done");
  endtask

  // Persistence of four with 64-cycle integrations: quiet at 128 cycles.
  task t_alert;
    wr(8'h02, 8'h10);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h8b);
    wait_done;
    chk({15'h0000, integ_active}, 16'h0001);
    wait_alert(300, 1'b0);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h08);
    rd(8'h06, 8'h0f);
    rd(8'h07, 8'h00);
    light <= 15'h1234;
    wait_alert(128, 1'b0);
    wait_alert(172, 1'b1);
    rd(8'h01, 8'h21);
    light <= 15'h0800;
    wr(8'h01, 8'h01);
    wait_alert(2, 1'b0);
    light <= 15'h7f00;
    wait_alert(300, 1'b1);
    light <= 15'h0800;
    xfer(1'b0, 8'h40, 1'b0, 8'h00);
    wait_alert(2, 1'b0);
    $display("alert done");
  endtask

  // The sample moves after the restart; host timing must not end again.
  task t_restart;
    wr(8'h00, 8'hab);
    light <= 15'h4321;
    xfer(1'b0, 8'h80, 1'b0, 8'h00);
    light <= 15'h0100;
    rd(8'h04, 8'h21);
    rd(8'h05, 8'hc3);
    $display("restart done");
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    t_regs;
    t_alert;
    t_restart;
    print_verdict;
  end
endmodule
